// ### logic/dll_tune.v
/*
  Phase detector and delay tuner of one delay-locked loop. Compares the
  incoming clock level with the distributed feedback level and steers a
  delay tap until their rising edges coincide.
  Assumes both levels are synchronous samples on sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gclk_dll_map.vh"

module dll_tune
(
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Sampled clock levels
  input wire ref_lvl_i,
  input wire fb_lvl_i,
  // Loop state
  output reg [`TAP_W-1:0] tap_o,
  output reg [`PER_W-1:0] period_o,
  output reg locked_o
);

  localparam [2:0] ST_MEASURE = 3'b001;
  localparam [2:0] ST_TRACK = 3'b010;
  localparam [2:0] ST_LOCKED = 3'b100;

  reg [2:0] state;
  reg ref_d;
  reg fb_d;
  reg [`PER_W-1:0] per_cnt;
  reg [`PER_W-1:0] lag_cnt;
  reg [`LOCK_CNT_W-1:0] match_cnt;
  reg per_ok;

  wire ref_rise = ref_lvl_i & ~ref_d;
  wire fb_rise = fb_lvl_i & ~fb_d;
  wire aligned = ref_rise & fb_rise;
  wire [`PER_W-1:0] half_per = {1'b0, period_o[`PER_W-1:1]};

  // Edge history and period measurement between reference rises
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ref_d <= 1'b0;
      fb_d <= 1'b0;
      per_cnt <= 5'h00;
      period_o <= 5'h00;
      per_ok <= 1'b0;
      lag_cnt <= 5'h00;
    end
    else
    begin
      ref_d <= ref_lvl_i;
      fb_d <= fb_lvl_i;
      if (ref_rise)
      begin
        per_cnt <= 5'h01;
        period_o <= per_cnt;
        per_ok <= (per_cnt >= `PER_MIN) && (per_cnt <= `PER_MAX);
        lag_cnt <= 5'h01;
      end
      else
      begin
        if (per_cnt != 5'h1F)
          per_cnt <= per_cnt + 5'h01;
        if (lag_cnt != 5'h1F)
          lag_cnt <= lag_cnt + 5'h01;
      end
    end
  end

  // RQ3 compare and tune
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_MEASURE;
      tap_o <= 6'h00;
      match_cnt <= 4'h0;
      locked_o <= 1'b0;
    end
    else
    begin
      case (state)
        ST_MEASURE:
        begin
          locked_o <= 1'b0;
          match_cnt <= 4'h0;
          if (per_ok)
            state <= ST_TRACK;
        end
        ST_TRACK, ST_LOCKED:
        begin
          if (!per_ok)
          begin
            // RQ11 lock lost
            state <= ST_MEASURE;
            locked_o <= 1'b0;
          end
          else if (aligned)
          begin
            if (match_cnt != `LOCK_CNT)
              match_cnt <= match_cnt + 4'h1;
            // RQ11 lock report
            if (match_cnt == `LOCK_CNT - 4'h1)
            begin
              state <= ST_LOCKED;
              locked_o <= 1'b1;
            end
          end
          else if (fb_rise)
          begin
            match_cnt <= 4'h0;
            state <= ST_TRACK;
            locked_o <= 1'b0;
            // Feedback late by at most half a period: shorten delay
            if (lag_cnt <= half_per && !ref_rise)
            begin
              if (tap_o != 6'h00)
                tap_o <= tap_o - 6'h01;
            end
            // RQ4 otherwise lengthen, wrapping to tap 0 past the end of the line
            else if (tap_o != `TAP_MAX)
              tap_o <= tap_o + 6'h01;
            else
              tap_o <= 6'h00;
          end
        end
        default:
        begin
          state <= ST_MEASURE;
          locked_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // dll_tune

`default_nettype wire

// ### logic/gclk_dll_map.vh
/*
  Constants for the global clock distribution block: delay line size,
  loop thresholds, output selector codes and divisor codes.
  Assumes it is included by bare name from the design files.
*/
`ifndef GCLK_DLL_MAP_VH
`define GCLK_DLL_MAP_VH

// ----------------------------------------
// Structure
// ----------------------------------------
`define NUM_GBUF 4
`define DLY_LEN 64
`define TAP_W 6
`define TAP_MAX 6'h3F
`define PER_W 5
// Longest input period the loop accepts, in system clock cycles
`define PER_MAX 5'h10
`define PER_MIN 5'h04

// ----------------------------------------
// Loop timing
// ----------------------------------------
// Consecutive aligned edges needed before lock is reported
`define LOCK_CNT 4'h8
`define LOCK_CNT_W 4

// ----------------------------------------
// Net output selector codes
// ----------------------------------------
`define SEL_W 3
`define SEL_PH0 3'h0
`define SEL_PH90 3'h1
`define SEL_PH180 3'h2
`define SEL_PH270 3'h3
`define SEL_DBL 3'h4
`define SEL_DIV 3'h5
`define SEL_BYPASS 3'h6

// ----------------------------------------
// Divisor codes, counted in half input periods
// ----------------------------------------
`define DIV_W 3
`define DIV_1P5 3'h0
`define DIV_2 3'h1
`define DIV_2P5 3'h2
`define DIV_3 3'h3
`define DIV_4 3'h4
`define DIV_5 3'h5
`define DIV_8 3'h6
`define DIV_16 3'h7
`define HALF_W 6

`endif

// ### logic/global_clock_dll_distribution.v
/*
  Four global clock buffers, each with a delay-locked loop, feeding four
  primary clock nets, with phase, doubled and divided outputs, board
  mirror outputs and a start-up hold until lock.
  Assumes all clock inputs are sampled levels on sys_clk_i (100 MHz) and
  that input clocks are slow enough to be seen as such.
*/
// Overview of operation
// RQ1 - Four global buffers each drive one primary net that reaches every clock load.
// RQ2 - Each buffer takes its input from its own clock pad or from fabric routing by configuration.
// RQ3 - Each loop compares input and distributed clock and keeps tuning a delay tap to align them.
// RQ4 - When aligned, input edges reach the loads one to four input periods later.
// RQ5 - One loop can feed up to two global nets at once.
// RQ6 - Each loop gives four quadrature phases a quarter period apart.
// RQ7 - Each loop gives a clock at twice the input frequency.
// RQ8 - Each loop gives a divided clock by 1.5, 2, 2.5, 3, 4, 5, 8 or 16.
// RQ9 - Start-up completion is held off until every loop chosen for it reports lock.
// RQ10 - A loop output can be driven off-chip and its feedback taken from a board return path.
// RQ11 - Each loop has a lock output, low from reset until aligned, high while alignment holds.
`timescale 1ns/1ps
`default_nettype none
`include "gclk_dll_map.vh"

module global_clock_dll_distribution
(
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Clock sources
  input wire [3:0] pad_clk_i,
  input wire [3:0] fabric_clk_i,
  input wire [3:0] src_fabric_sel_i,
  // Feedback paths
  input wire [3:0] net_fb_i,
  input wire [3:0] mirror_fb_i,
  input wire [3:0] fb_mirror_sel_i,
  // Net source configuration, three bits per net for output selector codes and three bits per loop for divisor codes
  input wire [11:0] net_out_sel_i,
  input wire [3:0] net_partner_sel_i,
  input wire [11:0] div_sel_i,
  input wire [3:0] mirror_en_i,
  // Start-up control
  input wire [3:0] startup_wait_lock_i,
  input wire startup_req_i,
  // Clock outputs
  output reg [3:0] gclk_net_o,
  output reg [3:0] mirror_o,
  // Status
  output reg [3:0] lock_o,
  output reg startup_done_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Keep a tap index inside the delay line
  function [`TAP_W-1:0] clamp_idx;
    input [`TAP_W:0] idx;
    begin
      if (idx > {1'b0, `TAP_MAX})
        clamp_idx = `TAP_MAX;
      else
        clamp_idx = idx[`TAP_W-1:0];
    end
  endfunction

  // Divisor code to length of the output period in input half periods
  function [`HALF_W-1:0] half_len;
    input [`DIV_W-1:0] code;
    begin
      case (code)
        `DIV_1P5: half_len = 6'h03;
        `DIV_2: half_len = 6'h04;
        `DIV_2P5: half_len = 6'h05;
        `DIV_3: half_len = 6'h06;
        `DIV_4: half_len = 6'h08;
        `DIV_5: half_len = 6'h0A;
        `DIV_8: half_len = 6'h10;
        `DIV_16: half_len = 6'h20;
        default: half_len = 6'h04;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Configuration capture
  // ----------------------------------------
  reg [3:0] cfg_src_fab;
  reg [3:0] cfg_fb_mir;
  reg [11:0] cfg_out_sel;
  reg [3:0] cfg_partner;
  reg [11:0] cfg_div_sel;

  // Selectors decode from flops, so each net switches source on one edge only
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_src_fab <= 4'h0;
      cfg_fb_mir <= 4'h0;
      cfg_out_sel <= 12'h000;
      cfg_partner <= 4'h0;
      cfg_div_sel <= 12'h000;
    end
    else
    begin
      cfg_src_fab <= src_fabric_sel_i;
      cfg_fb_mir <= fb_mirror_sel_i;
      cfg_out_sel <= net_out_sel_i;
      cfg_partner <= net_partner_sel_i;
      cfg_div_sel <= div_sel_i;
    end
  end

  // ----------------------------------------
  // Per buffer signals
  // ----------------------------------------
  wire [3:0] src_lvl;
  wire [3:0] lock_w;
  reg [3:0] ph0;
  reg [3:0] ph90;
  reg [3:0] ph180;
  reg [3:0] ph270;
  reg [3:0] dbl;
  reg [3:0] divclk;
  reg [3:0] byp;
  reg [3:0] ph0_d;
  reg [3:0] net_sel_lvl;

  genvar g;
  generate
    for (g = 0; g < `NUM_GBUF; g = g + 1)
    begin : gbuf
      reg [`DLY_LEN-1:0] dly;
      reg [`HALF_W-1:0] half_cnt;
      wire [`TAP_W-1:0] tap;
      wire [`PER_W-1:0] period;
      wire [`TAP_W-1:0] quarter;
      wire [`TAP_W-1:0] i0;
      wire [`TAP_W-1:0] i90;
      wire [`TAP_W-1:0] i180;
      wire [`TAP_W-1:0] i270;
      wire [`HALF_W-1:0] hlen;
      wire [`HALF_W-1:0] hhigh;
      wire [`HALF_W-1:0] next_half_cnt;
      wire fb_lvl;
      wire [`SEL_W-1:0] osel;
      wire own;

      // RQ2 pad or fabric input
      assign src_lvl[g] = cfg_src_fab[g] ? fabric_clk_i[g] : pad_clk_i[g];

      // RQ10 feedback from board return path or internal net
      assign fb_lvl = cfg_fb_mir[g] ? mirror_fb_i[g] : net_fb_i[g];

      // Delay line of input samples
      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          dly <= 64'h0000000000000000;
        else
          dly <= {dly[`DLY_LEN-2:0], src_lvl[g]};
      end

      // RQ3 loop tuner
      dll_tune u_tune
      (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ref_lvl_i(src_lvl[g]),
        .fb_lvl_i(fb_lvl),
        .tap_o(tap),
        .period_o(period),
        .locked_o(lock_w[g])
      );

      // RQ6 taps a quarter period apart
      assign quarter = {3'b000, period[`PER_W-1:2]};
      assign i0 = tap;
      assign i90 = clamp_idx({1'b0, tap} + {1'b0, quarter});
      assign i180 = clamp_idx({1'b0, tap} + {1'b0, quarter[`TAP_W-2:0], 1'b0});
      assign i270 = clamp_idx({1'b0, tap} + {1'b0, quarter} + {quarter, 1'b0});

      // Phase, doubled and bypass levels
      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          ph0[g] <= 1'b0;
          ph90[g] <= 1'b0;
          ph180[g] <= 1'b0;
          ph270[g] <= 1'b0;
          dbl[g] <= 1'b0;
          byp[g] <= 1'b0;
          ph0_d[g] <= 1'b0;
        end
        else
        begin
          ph0[g] <= dly[i0];
          ph90[g] <= dly[i90];
          ph180[g] <= dly[i180];
          ph270[g] <= dly[i270];
          // RQ7 two rises per input period
          dbl[g] <= dly[i0] ^ dly[i90];
          byp[g] <= src_lvl[g];
          ph0_d[g] <= ph0[g];
        end
      end

      // RQ8 divider counts half periods of the aligned clock
      assign hlen = half_len(cfg_div_sel[g*3 +: 3]);
      assign hhigh = hlen - {1'b0, hlen[`HALF_W-1:1]};
      assign next_half_cnt = (half_cnt >= hlen - 6'h01) ? 6'h00 : half_cnt + 6'h01;

      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          half_cnt <= 6'h00;
          divclk[g] <= 1'b0;
        end
        else if (ph0[g] ^ ph0_d[g])
        begin
          half_cnt <= next_half_cnt;
          divclk[g] <= next_half_cnt < hhigh;
        end
      end

      // RQ5 net takes its own loop or the partner loop of its pair
      assign own = ~cfg_partner[g];
      assign osel = cfg_out_sel[g*3 +: 3];

      always @*
      begin
        case (osel)
          `SEL_PH0: net_sel_lvl[g] = own ? ph0[g] : ph0[g^1];
          `SEL_PH90: net_sel_lvl[g] = own ? ph90[g] : ph90[g^1];
          `SEL_PH180: net_sel_lvl[g] = own ? ph180[g] : ph180[g^1];
          `SEL_PH270: net_sel_lvl[g] = own ? ph270[g] : ph270[g^1];
          `SEL_DBL: net_sel_lvl[g] = own ? dbl[g] : dbl[g^1];
          `SEL_DIV: net_sel_lvl[g] = own ? divclk[g] : divclk[g^1];
          `SEL_BYPASS: net_sel_lvl[g] = own ? byp[g] : byp[g^1];
          default: net_sel_lvl[g] = own ? ph0[g] : ph0[g^1];
        endcase
      end

      // RQ1 one buffer drives one primary net
      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          gclk_net_o[g] <= 1'b0;
          mirror_o[g] <= 1'b0;
          lock_o[g] <= 1'b0;
        end
        else
        begin
          gclk_net_o[g] <= net_sel_lvl[g];
          // RQ10 mirror copy driven off-chip
          mirror_o[g] <= mirror_en_i[g] & net_sel_lvl[g];
          // RQ11 lock status
          lock_o[g] <= lock_w[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Start-up hold
  // ----------------------------------------

  localparam [1:0] SU_HOLD = 2'b01;
  localparam [1:0] SU_RUN = 2'b10;

  reg [1:0] su_state;
  // Chosen loops that have not locked yet
  wire [3:0] loops_pending = startup_wait_lock_i & ~lock_w;

  // RQ9 release only when every chosen loop is locked
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      su_state <= SU_HOLD;
      startup_done_o <= 1'b0;
    end
    else
    begin
      case (su_state)
        SU_HOLD:
        begin
          startup_done_o <= 1'b0;
          if (startup_req_i && (loops_pending == 4'h0))
          begin
            su_state <= SU_RUN;
            startup_done_o <= 1'b1;
          end
        end
        // Done is sticky until the next reset
        SU_RUN:
          startup_done_o <= 1'b1;
        default:
        begin
          su_state <= SU_HOLD;
          startup_done_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // global_clock_dll_distribution

`default_nettype wire

// ### tb/gclk_load_model.sv
/*
  Clock load model: distribution delay of each net and board return path.
  Assumes net and mirror levels change on sys_clk_i rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module gclk_load_model #(parameter int DLY = 5)
(
  // Clock
  input wire logic clk_i,
  // Levels from the block
  input wire logic [3:0] net_i,
  input wire logic [3:0] mirror_i,
  // Levels back to the block
  output var logic [3:0] net_fb_o,
  output var logic [3:0] mirror_fb_o
);
  logic [4*DLY-1:0] net_sr = '0;
  logic [4*DLY-1:0] mir_sr = '0;
  always @(posedge clk_i)
  begin
    net_sr <= {net_sr[4*DLY-5:0], net_i};
    mir_sr <= {mir_sr[4*DLY-5:0], mirror_i};
  end
  // Far ends of the delay chains
  assign net_fb_o = net_sr[4*DLY-1 -: 4];
  assign mirror_fb_o = mir_sr[4*DLY-1 -: 4];
endmodule // gclk_load_model
`default_nettype wire

// ### tb/global_clock_dll_distribution_chk.sv
/*
  Checker for the global clock block: reset, lock, start-up and mirror.
  Assumes it is bound to the ports of the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module gclk_chk
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic [3:0] mirror_en_i,
  input wire logic [3:0] startup_wait_lock_i,
  input wire logic startup_req_i,
  input wire logic [3:0] gclk_net_o,
  input wire logic [3:0] mirror_o,
  input wire logic [3:0] lock_o,
  input wire logic startup_done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0] run_cnt;
  // Cycles since reset release, saturating
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      run_cnt <= 6'h00;
    else if (run_cnt != 6'h3F)
      run_cnt <= run_cnt + 6'h01;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst_quiet;
    $rose(rst_n_i) |-> (gclk_net_o | mirror_o | lock_o) == 4'h0 && !startup_done_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy at reset");
  property p_lock_late;
    (lock_o & ~$past(lock_o)) != 4'h0 |-> run_cnt > 6'h1E;
  endproperty
  a_lock_late: assert property (p_lock_late) else $error("lock too early");
  property p_lock_hold;
    $rose(lock_o[0]) |-> lock_o[0] [*3];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock pulse short");
  property p_start_req;
    $rose(startup_done_o) |-> $past(startup_req_i);
  endproperty
  a_start_req: assert property (p_start_req) else $error("done without request");
  property p_start_lock;
    $rose(startup_done_o) |-> ##1 (startup_wait_lock_i & ~lock_o) == 4'h0;
  endproperty
  a_start_lock: assert property (p_start_lock) else $error("done before lock");
  property p_start_keep;
    startup_done_o |=> startup_done_o;
  endproperty
  a_start_keep: assert property (p_start_keep) else $error("done fell");
  property p_mirror_off;
    (mirror_o & ~$past(mirror_en_i)) == 4'h0;
  endproperty
  a_mirror_off: assert property (p_mirror_off) else $error("mirror off but driven");
  property p_mirror_copy;
    mirror_en_i[3] && $rose(gclk_net_o[3]) |-> ##[0:1] mirror_o[3];
  endproperty
  a_mirror_copy: assert property (p_mirror_copy) else $error("mirror lost net");
endmodule // gclk_chk
bind global_clock_dll_distribution gclk_chk chk_u (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .mirror_en_i(mirror_en_i), .startup_wait_lock_i(startup_wait_lock_i),
  .startup_req_i(startup_req_i), .gclk_net_o(gclk_net_o), .mirror_o(mirror_o),
  .lock_o(lock_o), .startup_done_o(startup_done_o));
`default_nettype wire

// ### tb/test_global_clock_dll_distribution.sv
/*
  Bench for the global clock block: lock, start-up, output selection,
  dividers, mirror feedback, refused periods and reset.
  Assumes the load model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_global_clock_dll_distribution;
  typedef struct { logic [2:0] sel; logic [2:0] dv; int rises; } row_t;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] pad_clk_i = 4'h0;
  logic [3:0] fabric_clk_i = 4'h0;
  logic [3:0] net_fb_i;
  logic [3:0] mirror_fb_i;
  logic [11:0] net_out_sel_i = 12'h000;
  logic [3:0] net_partner_sel_i = 4'h0;
  logic [11:0] div_sel_i = 12'h000;
  logic startup_req_i = 1'b0;
  logic [3:0] startup_wait_lock_i = 4'hF;
  logic [3:0] gclk_net_o;
  logic [3:0] mirror_o;
  logic [3:0] lock_o;
  logic startup_done_o;
  int per = 8;
  int ph = 0;
  int mismatches = 0;
  int compares = 0;
  int r;
  int a;
  int b;
  logic pp;
  logic fp;
  // Selection, divisor code and rising edges in 1920 cycles
  row_t rows [15] = '{'{3'h0, 3'h0, 240}, '{3'h1, 3'h0, 240}, '{3'h2, 3'h0, 240},
    '{3'h3, 3'h0, 240}, '{3'h4, 3'h0, 480}, '{3'h6, 3'h0, 240}, '{3'h7, 3'h0, 240},
    '{3'h5, 3'h0, 160}, '{3'h5, 3'h1, 120}, '{3'h5, 3'h2, 96}, '{3'h5, 3'h3, 80},
    '{3'h5, 3'h4, 60}, '{3'h5, 3'h5, 48}, '{3'h5, 3'h6, 30}, '{3'h5, 3'h7, 15}};
  always #5 sys_clk_i = ~sys_clk_i;
  // good clock on pads 0,1,3 and fabric 2
  always @(posedge sys_clk_i)
  begin
    ph <= (ph + 1) % per;
    pad_clk_i <= (ph < per / 2) ? 4'hB : 4'h0;
    fabric_clk_i <= (ph < per / 2) ? 4'h4 : 4'h0;
  end
  global_clock_dll_distribution dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .pad_clk_i(pad_clk_i), .fabric_clk_i(fabric_clk_i), .src_fabric_sel_i(4'h4),
    .net_fb_i(net_fb_i), .mirror_fb_i(mirror_fb_i), .fb_mirror_sel_i(4'h8),
    .net_out_sel_i(net_out_sel_i), .net_partner_sel_i(net_partner_sel_i),
    .div_sel_i(div_sel_i), .mirror_en_i(4'h8), .startup_wait_lock_i(startup_wait_lock_i),
    .startup_req_i(startup_req_i), .gclk_net_o(gclk_net_o), .mirror_o(mirror_o),
    .lock_o(lock_o), .startup_done_o(startup_done_o));
  gclk_load_model load_u (.clk_i(sys_clk_i), .net_i(gclk_net_o), .mirror_i(mirror_o),
    .net_fb_o(net_fb_i), .mirror_fb_o(mirror_fb_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_v(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_n(input string what, input int exp, input int got);
    compares++;
    if (got < exp - 1 || got > exp + 1)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask
  task automatic wait_lock();
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (lock_o !== 4'hF && n < 3000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check_v("lock", 4'hF, lock_o);
    if (lock_o !== 4'hF)
      give_verdict();
    else
      @(posedge sys_clk_i);
  endtask
  task automatic count_rises(input int n, output int c);
    logic prev;
    c = 0;
    @(negedge sys_clk_i);
    prev = gclk_net_o[1];
    repeat (n)
    begin
      @(negedge sys_clk_i);
      if (gclk_net_o[1] === 1'b1 && prev === 1'b0)
        c++;
      prev = gclk_net_o[1];
    end
  endtask
  // Cycles from a rise of net 0 to the next rise of net 1
  task automatic phase_lag(output int d);
    logic p0;
    logic p1;
    int n;
    n = 0;
    d = 0;
    @(negedge sys_clk_i);
    p0 = gclk_net_o[0];
    p1 = gclk_net_o[1];
    @(negedge sys_clk_i);
    while (!(gclk_net_o[0] === 1'b1 && p0 === 1'b0) && n < 64)
    begin
      p0 = gclk_net_o[0];
      p1 = gclk_net_o[1];
      @(negedge sys_clk_i);
      n++;
    end
    while (!(gclk_net_o[1] === 1'b1 && p1 === 1'b0) && d < 16)
    begin
      p1 = gclk_net_o[1];
      @(negedge sys_clk_i);
      d++;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wait_lock();
    check_v("done", 4'h0, {3'h0, startup_done_o});
    startup_req_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check_v("done", 4'h1, {3'h0, startup_done_o});
    a = 0;
    b = 0;
    pp = pad_clk_i[0];
    fp = net_fb_i[0];
    repeat (64)
    begin
      @(negedge sys_clk_i);
      a += (pad_clk_i[0] && !pp);
      b += (pad_clk_i[0] && !pp && net_fb_i[0] && !fp);
      pp = pad_clk_i[0];
      fp = net_fb_i[0];
    end
    check_n("aligned edges", a, b);
    @(posedge sys_clk_i);
    net_partner_sel_i <= 4'h2;
    foreach (rows[i])
    begin
      @(posedge sys_clk_i);
      net_out_sel_i <= {6'h00, rows[i].sel, 3'h0};
      div_sel_i <= {9'h000, rows[i].dv};
      repeat (256) @(posedge sys_clk_i);
      count_rises(1920, r);
      check_n("net rises", rows[i].rises, r);
      if (rows[i].sel < 3'h4)
      begin
        phase_lag(r);
        check_v("net phase", 4'((per / 4) * rows[i].sel), 4'(r));
      end
    end
    @(posedge sys_clk_i);
    net_partner_sel_i <= 4'h0;
    net_out_sel_i <= 12'h000;
    per <= 20;
    repeat (200) @(posedge sys_clk_i);
    check_v("lock slow", 4'h0, lock_o);
    per <= 3;
    repeat (200) @(posedge sys_clk_i);
    check_v("lock fast", 4'h0, lock_o);
    check_v("done kept", 4'h1, {3'h0, startup_done_o});
    per <= 8;
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    check_v("reset", 4'h0, gclk_net_o | mirror_o | lock_o | {3'h0, startup_done_o});
    rst_n_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    check_v("done held", 4'h0, {3'h0, startup_done_o});
    wait_lock();
    repeat (2) @(posedge sys_clk_i);
    check_v("done again", 4'h1, {3'h0, startup_done_o});
    rst_n_i <= 1'b0;
    startup_wait_lock_i <= 4'h0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    check_v("done unchosen", 4'h1, {3'h0, startup_done_o});
    check_v("lock unchosen", 4'h0, lock_o);
    give_verdict();
  end
endmodule // test_global_clock_dll_distribution
`default_nettype wire
